/* File: lcw_defines.svh */
// Constants of the character panel write controller: timing, commands, widths.
// Assumes a single 100 MHz ref_clk; every count below derives from its period.
`ifndef LCW_DEFINES_SVH
`define LCW_DEFINES_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define LCW_CLK_PERIOD_NS 10
`define LCW_POWER_WAIT_MS 15
`define LCW_HOLD_MS       16
`define LCW_SETUP_NS      60
`define LCW_PULSE_NS      460
`define LCW_DATA_HOLD_NS  20
`define LCW_EXEC_US       40
`define LCW_HOLD_CYC      ((`LCW_HOLD_MS * 1000000) / `LCW_CLK_PERIOD_NS)
`define LCW_SETUP_CYC     ((`LCW_SETUP_NS + `LCW_CLK_PERIOD_NS - 1) / `LCW_CLK_PERIOD_NS)
`define LCW_PULSE_CYC     ((`LCW_PULSE_NS + `LCW_CLK_PERIOD_NS - 1) / `LCW_CLK_PERIOD_NS)
`define LCW_DHOLD_CYC     ((`LCW_DATA_HOLD_NS + `LCW_CLK_PERIOD_NS - 1) / `LCW_CLK_PERIOD_NS)
`define LCW_EXEC_CYC      ((`LCW_EXEC_US * 1000 + `LCW_CLK_PERIOD_NS - 1) / `LCW_CLK_PERIOD_NS)
`define LCW_CNT_W         24

// ****************************************************************
// Setup commands and levels
// ****************************************************************
`define LCW_CMD_FUNC      8'h38
`define LCW_CMD_ENTRY     8'h06
`define LCW_CMD_DISPLAY   8'h0E
`define LCW_CMD_CLEAR     8'h01
`define LCW_CMD_LAST      2'h3
`define LCW_RW_WRITE      1'h0
`define LCW_RS_COMMAND    1'h0
`define LCW_RS_DATA       1'h1

`endif

/* File: lcw_pkg.sv */
// Types shared by the panel write controller modules.
// Assumes lcw_defines.svh for widths.
`default_nettype none
`include "lcw_defines.svh"

package lcw_pkg;

  // ****************************************************************
  // Common types
  // ****************************************************************
  typedef logic [7:0]              lcw_byte_t;
  typedef logic [`LCW_CNT_W-1:0]   lcw_cnt_t;

  // Power-up sequencer states, one-hot
  typedef enum logic [4:0] {
    PU_WAIT  = 5'h01,
    PU_SETUP = 5'h02,
    PU_PULSE = 5'h04,
    PU_HOLD  = 5'h08,
    PU_DONE  = 5'h10
  } lcw_pu_state_e;

  // Main machine states, one-hot
  typedef enum logic [5:0] {
    MS_INIT  = 6'h01,
    MS_READY = 6'h02,
    MS_SETUP = 6'h04,
    MS_PULSE = 6'h08,
    MS_HOLD  = 6'h10,
    MS_EXEC  = 6'h20
  } lcw_main_state_e;

endpackage

`default_nettype wire

/* File: lcw_init_if.sv */
// Link from the power-up sequencer to the main controller.
// Assumes both ends run on the same ref_clk.
`default_nettype none

interface lcw_init_if;
  logic              done;
  lcw_pkg::lcw_byte_t cmd_bus;
  logic              cmd_strobe;

  // Sequencer drives, controller listens
  modport seq  (output done, output cmd_bus, output cmd_strobe);
  modport ctrl (input done, input cmd_bus, input cmd_strobe);
endinterface

`default_nettype wire

/* File: lcw_power_up.sv */
// Power-up sequencer: waits, then writes the four setup commands.
// Assumes the main controller forwards cmd_bus/cmd_strobe until done rises.
`default_nettype none
`include "lcw_defines.svh"

module lcw_power_up #(
  parameter int HOLD_CYCLES = `LCW_HOLD_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Toward main controller
  lcw_init_if.seq   init
);

  lcw_pkg::lcw_pu_state_e state_reg, state_next;
  lcw_pkg::lcw_cnt_t      cnt_reg, cnt_next;
  logic [1:0]             idx_reg, idx_next;
  lcw_pkg::lcw_byte_t     bus_reg;
  logic                   strobe_reg;
  lcw_pkg::lcw_byte_t     cmd_byte;
  wire logic hold_end  = (cnt_reg == `LCW_CNT_W'(HOLD_CYCLES - 1));
  wire logic setup_end = (cnt_reg == `LCW_CNT_W'(`LCW_SETUP_CYC - 1));
  wire logic pulse_end = (cnt_reg == `LCW_CNT_W'(`LCW_PULSE_CYC - 1));

  // Command order leaves cursor on, screen clear, auto-increment
  assign cmd_byte = (idx_reg == 2'h0) ? `LCW_CMD_FUNC :
                    (idx_reg == 2'h1) ? `LCW_CMD_ENTRY :
                    (idx_reg == 2'h2) ? `LCW_CMD_DISPLAY : `LCW_CMD_CLEAR;

  // Next state; power wait reuses the 16 ms hold, which covers 15 ms
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    case (state_reg)
      lcw_pkg::PU_WAIT:  if (hold_end) state_next = lcw_pkg::PU_SETUP;
      lcw_pkg::PU_SETUP: if (setup_end) state_next = lcw_pkg::PU_PULSE;
      lcw_pkg::PU_PULSE: if (pulse_end) state_next = lcw_pkg::PU_HOLD;
      lcw_pkg::PU_HOLD: begin
        if (hold_end) begin
          if (idx_reg == `LCW_CMD_LAST) begin
            state_next = lcw_pkg::PU_DONE;
          end else begin
            idx_next   = idx_reg + 2'h1;
            state_next = lcw_pkg::PU_SETUP;
          end
        end
      end
      lcw_pkg::PU_DONE:  state_next = lcw_pkg::PU_DONE;
      default:           state_next = lcw_pkg::PU_WAIT;
    endcase
  end

  assign cnt_next = (state_next != state_reg) ? '0 : cnt_reg + `LCW_CNT_W'(1);

  // Registers; reset restarts from the power wait
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg  <= lcw_pkg::PU_WAIT;
      cnt_reg    <= '0;
      idx_reg    <= 2'h0;
      bus_reg    <= 8'h00;
      strobe_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      idx_reg    <= idx_next;
      bus_reg    <= (state_next == lcw_pkg::PU_WAIT) ? 8'h00 : cmd_byte;
      strobe_reg <= (state_next == lcw_pkg::PU_PULSE);
    end
  end

  assign init.done       = (state_reg == lcw_pkg::PU_DONE);
  assign init.cmd_bus    = bus_reg;
  assign init.cmd_strobe = strobe_reg;

endmodule

`default_nettype wire

/* File: lcw_ctrl.sv */
// Top of the character panel write controller.
// Assumes an upstream host on asynchronous pins and a write-only panel.
`default_nettype none
`include "lcw_defines.svh"

module lcw_ctrl #(
  parameter int HOLD_CYCLES = `LCW_HOLD_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Host side
  input  wire logic [7:0] host_byte_in,
  input  wire logic       host_write,
  output logic            ready,
  // Panel side
  output logic            panel_reg_select,
  output logic            panel_read_write,
  output logic            panel_strobe,
  output logic [7:0]      panel_bus
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  lcw_init_if init_link ();

  // Host pin synchronisers, three stages each
  logic               write_s1_reg;
  logic               write_s2_reg;
  logic               write_s3_reg;
  lcw_pkg::lcw_byte_t byte_s1_reg;
  lcw_pkg::lcw_byte_t byte_s2_reg;
  lcw_pkg::lcw_byte_t byte_s3_reg;
  logic               write_level_reg;
  logic               write_level_next;

  // Main machine
  lcw_pkg::lcw_main_state_e state_reg;
  lcw_pkg::lcw_main_state_e state_next;
  lcw_pkg::lcw_cnt_t        cnt_reg;
  lcw_pkg::lcw_cnt_t        cnt_next;
  lcw_pkg::lcw_byte_t       char_reg;
  lcw_pkg::lcw_byte_t       char_next;

  // Panel output registers
  logic               rs_reg;
  logic               rs_next;
  logic               strobe_reg;
  logic               strobe_next;
  lcw_pkg::lcw_byte_t bus_reg;
  lcw_pkg::lcw_byte_t bus_next;

  // ****************************************************************
  // Power-up sequencer
  // ****************************************************************
  lcw_power_up #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_power_up (
    .ref_clk (ref_clk),
    .reset   (reset),
    .init    (init_link.seq)
  );

  // ****************************************************************
  // Host strobe and data synchronisers
  // ****************************************************************

  // Data rides the same three stages as the strobe, so the byte seen
  // at the third stage is the one present when the strobe fell
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      write_s1_reg <= 1'b0;
      write_s2_reg <= 1'b0;
      write_s3_reg <= 1'b0;
      byte_s1_reg  <= 8'h00;
      byte_s2_reg  <= 8'h00;
      byte_s3_reg  <= 8'h00;
    end else begin
      write_s1_reg <= host_write;
      write_s2_reg <= write_s1_reg;
      write_s3_reg <= write_s2_reg;
      byte_s1_reg  <= host_byte_in;
      byte_s2_reg  <= byte_s1_reg;
      byte_s3_reg  <= byte_s2_reg;
    end
  end

  // A strobe change counts only once stages two and three agree
  wire logic write_agree = (write_s2_reg == write_s3_reg);
  wire logic write_fall  = write_agree & ~write_s3_reg & write_level_reg;

  assign write_level_next = write_agree ? write_s3_reg : write_level_reg;

  // Filtered strobe level, tracked even while busy so that a strobe
  // that rose and fell within a busy period never looks like a new fall
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      write_level_reg <= 1'b0;
    end else begin
      write_level_reg <= write_level_next;
    end
  end

  // ****************************************************************
  // Main state machine decode
  // ****************************************************************

  // Terminal counts of the character write phases
  wire logic setup_end = (cnt_reg == `LCW_CNT_W'(`LCW_SETUP_CYC - 1));
  wire logic pulse_end = (cnt_reg == `LCW_CNT_W'(`LCW_PULSE_CYC - 1));
  wire logic dhold_end = (cnt_reg == `LCW_CNT_W'(`LCW_DHOLD_CYC - 1));
  wire logic exec_end  = (cnt_reg == `LCW_CNT_W'(`LCW_EXEC_CYC - 1));

  // Only a fall seen while ready is high is taken
  wire logic in_ready  = (state_reg == lcw_pkg::MS_READY);
  wire logic take_byte = in_ready & write_fall;
  wire logic in_init   = (state_reg == lcw_pkg::MS_INIT);

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lcw_pkg::MS_INIT: begin
        if (init_link.done) begin
          state_next = lcw_pkg::MS_READY;
        end
      end
      lcw_pkg::MS_READY: begin
        if (take_byte) begin
          state_next = lcw_pkg::MS_SETUP;
        end
      end
      lcw_pkg::MS_SETUP: begin
        if (setup_end) begin
          state_next = lcw_pkg::MS_PULSE;
        end
      end
      lcw_pkg::MS_PULSE: begin
        if (pulse_end) begin
          state_next = lcw_pkg::MS_HOLD;
        end
      end
      lcw_pkg::MS_HOLD: begin
        if (dhold_end) begin
          state_next = lcw_pkg::MS_EXEC;
        end
      end
      lcw_pkg::MS_EXEC: begin
        // Panel is busy writing the character; no busy flag is read
        if (exec_end) begin
          state_next = lcw_pkg::MS_READY;
        end
      end
      default: begin
        state_next = lcw_pkg::MS_INIT;
      end
    endcase
  end

  // Phase counter clears on every state change
  assign cnt_next = (state_next != state_reg) ? '0 : cnt_reg + `LCW_CNT_W'(1);

  // Character latch loads only on an accepted fall
  assign char_next = take_byte ? byte_s3_reg : char_reg;

  // ****************************************************************
  // Panel line selection
  // ****************************************************************

  // Before done the sequencer owns the panel lines, after it the main
  // machine; the select line marks command versus character
  assign rs_next = in_init ? `LCW_RS_COMMAND : `LCW_RS_DATA;

  // Strobe rises after one setup phase; characters are stable through all of it, sequencer commands two to four from its second cycle
  assign strobe_next = in_init ? init_link.cmd_strobe
                               : (state_next == lcw_pkg::MS_PULSE);

  // Bus shows the latched byte from setup through the post-fall hold
  assign bus_next = in_init ? init_link.cmd_bus
                            : (take_byte ? byte_s3_reg : char_reg);

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Machine state; reset returns control to the sequencer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= lcw_pkg::MS_INIT;
      cnt_reg   <= '0;
      char_reg  <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      char_reg  <= char_next;
    end
  end

  // Select, strobe and bus lines registered, so the sequencer path and the main
  // path share one cycle of latency and keep their relative timing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rs_reg     <= `LCW_RS_COMMAND;
      strobe_reg <= 1'b0;
      bus_reg    <= 8'h00;
    end else begin
      rs_reg     <= rs_next;
      strobe_reg <= strobe_next;
      bus_reg    <= bus_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Ready is a handshake, so it follows the state directly
  assign ready            = in_ready;
  assign panel_reg_select = rs_reg;
  assign panel_read_write = `LCW_RW_WRITE;
  assign panel_strobe     = strobe_reg;
  assign panel_bus        = bus_reg;

endmodule

`default_nettype wire

/* File: lcw_ctrl_chk.sv */
// Checker for the panel write controller, bound to its top ports.
// Assumes one ref_clk domain and active-high asynchronous reset.
`default_nettype none

module lcw_ctrl_chk #(
  parameter int HOLD_CYCLES = 50
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // Host side
  input wire logic [7:0] host_byte_in,
  input wire logic       host_write,
  input wire logic       ready,
  // Panel side
  input wire logic       panel_reg_select,
  input wire logic       panel_read_write,
  input wire logic       panel_strobe,
  input wire logic [7:0] panel_bus
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] hi_cnt_reg;
  logic [2:0] cmd_cnt_reg;
  logic       seen_ready_reg;
  logic       strobe_q_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ****************************************************************
  // Helper counters
  // ****************************************************************
  // Strobe width, commands before first ready, first-ready flag
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hi_cnt_reg     <= '0;
      cmd_cnt_reg    <= '0;
      seen_ready_reg <= 1'b0;
      strobe_q_reg   <= 1'b0;
    end else begin
      hi_cnt_reg     <= panel_strobe ? hi_cnt_reg + 8'h01 : 8'h00;
      cmd_cnt_reg    <= cmd_cnt_reg + 3'((panel_strobe && !strobe_q_reg && !seen_ready_reg));
      seen_ready_reg <= seen_ready_reg | ready;
      strobe_q_reg   <= panel_strobe;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_hold;
    $stable(panel_bus) [*2];
  endsequence
  sequence s_busy;
    (!ready) [*8];
  endsequence

  property p_rw_write;
    panel_read_write == 1'b0;
  endproperty
  property p_quiet_ready;
    ready |-> !panel_strobe;
  endproperty
  property p_strobe_width;
    $fell(panel_strobe) |-> hi_cnt_reg == 8'h2E;
  endproperty
  property p_setup;
    $rose(panel_strobe) |-> $past(panel_bus, 5) == panel_bus
      && $past(panel_reg_select, 5) == panel_reg_select;
  endproperty
  property p_hold;
    $fell(panel_strobe) |-> s_hold;
  endproperty
  property p_ready_drop;
    ready && $fell(host_write) |-> ##[2:6] !ready;
  endproperty
  property p_rs_kind;
    $rose(panel_strobe) |-> panel_reg_select == seen_ready_reg;
  endproperty
  property p_init_count;
    $rose(ready) && !seen_ready_reg |-> cmd_cnt_reg == 3'h4;
  endproperty
  property p_busy;
    $fell(ready) |-> s_busy;
  endproperty

  a_rw_write: assert property (p_rw_write) else $error("read/write left write level");
  a_quiet_ready: assert property (p_quiet_ready) else $error("strobe while ready");
  a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
  a_setup: assert property (p_setup) else $error("bus moved before strobe");
  a_hold: assert property (p_hold) else $error("bus moved at strobe fall");
  a_ready_drop: assert property (p_ready_drop) else $error("ready kept after write");
  a_rs_kind: assert property (p_rs_kind) else $error("wrong select level");
  a_init_count: assert property (p_init_count) else $error("setup count wrong");
  a_busy: assert property (p_busy) else $error("ready back too soon");
endmodule

`default_nettype wire

/* File: lcw_panel_model.sv */
// Character panel model: logs what it takes on each strobe fall.
// Assumes write-only traffic; it drives nothing back.
`default_nettype none

module lcw_panel_model (
  // Panel lines
  input wire logic       panel_reg_select,
  input wire logic       panel_read_write,
  input wire logic       panel_strobe,
  input wire logic [7:0] panel_bus
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [8:0] taken_q[$];
  logic       armed;

  // Arm on a real rise so reset's x-to-0 is not taken
  initial armed = 1'b0;
  always @(posedge panel_strobe) armed = 1'b1;

  // Select and data are taken on the strobe's fall
  always @(negedge panel_strobe) begin
    if (armed && panel_read_write === 1'b0) begin
      taken_q.push_back({panel_reg_select, panel_bus});
    end
    armed = 1'b0;
  end
endmodule

`default_nettype wire

/* File: tb_lcw_ctrl.sv */
// Self-checking bench for the panel write controller.
// Assumes a short HOLD_CYCLES; expectations derive from it.
`default_nettype none

module tb_lcw_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HOLD = 50;

  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] host_byte_in = 8'h00;
  logic       host_write = 1'b0;
  logic       ready;
  logic       panel_reg_select;
  logic       panel_read_write;
  logic       panel_strobe;
  logic [7:0] panel_bus;
  int         failures = 0;
  int         compares = 0;
  logic [7:0] init_cmds [4] = '{8'h38, 8'h06, 8'h0E, 8'h01};

  lcw_ctrl #(.HOLD_CYCLES(HOLD)) u_lcw_ctrl (
    .ref_clk(ref_clk), .reset(reset), .host_byte_in(host_byte_in),
    .host_write(host_write), .ready(ready), .panel_reg_select(panel_reg_select),
    .panel_read_write(panel_read_write), .panel_strobe(panel_strobe), .panel_bus(panel_bus));
  lcw_panel_model u_lcw_panel_model (
    .panel_reg_select(panel_reg_select), .panel_read_write(panel_read_write),
    .panel_strobe(panel_strobe), .panel_bus(panel_bus));

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Bounded wait; a hang ends the run
  task automatic wait_ready(input int bound);
    int n;
    for (n = 0; n < bound && ready !== 1'b1; n++) @(posedge ref_clk) #1;
    if (n == bound) begin
      failures++;
      report_and_stop();
    end
  endtask

  // Reset, then check wait, setup list, select level and ready timing
  task automatic t_init();
    int n;
    int first;
    int last;
    first = 0;
    last = 0;
    u_lcw_panel_model.taken_q.delete();
    reset = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1 reset = 1'b0;
    for (n = 0; n < 3000 && ready !== 1'b1; n++) begin
      @(posedge ref_clk) #1;
      if (panel_strobe === 1'b1 && first == 0) first = n;
      if (panel_strobe === 1'b1) last = n;
    end
    chk(16'(ready), 16'h0001);
    chk(16'(first >= HOLD), 16'h0001);
    chk(16'(n - last <= HOLD + 8), 16'h0001);
    chk(16'(u_lcw_panel_model.taken_q.size()), 16'h0004);
    for (int i = 0; i < 4; i++) chk(16'(u_lcw_panel_model.taken_q[i]), {8'h00, init_cmds[i]});
  endtask

  // Host strobe; byte taken on the fall; callers wait for ready first, except t_busy's second strobe
  task automatic pulse_byte(input logic [7:0] b);
    host_byte_in = b;
    host_write = 1'b1;
    repeat (4) @(posedge ref_clk) #1;
    host_write = 1'b0;
    repeat (6) @(posedge ref_clk) #1;
  endtask

  // Back-to-back characters at boundary values
  task automatic t_chars();
    logic [7:0] vals [3] = '{8'h00, 8'hFF, 8'h5A};
    foreach (vals[i]) begin
      wait_ready(6000);
      pulse_byte(vals[i]);
      chk(16'(ready), 16'h0000);
      wait_ready(6000);
      chk(16'(u_lcw_panel_model.taken_q[$]), {7'h00, 1'b1, vals[i]});
    end
  endtask

  // Strobe during busy must be ignored
  task automatic t_busy();
    int sz;
    sz = u_lcw_panel_model.taken_q.size();
    pulse_byte(8'hA5);
    repeat (20) @(posedge ref_clk) #1;
    pulse_byte(8'h3C);
    wait_ready(6000);
    repeat (40) @(posedge ref_clk) #1;
    chk(16'(u_lcw_panel_model.taken_q.size() - sz), 16'h0001);
    chk(16'(u_lcw_panel_model.taken_q[$]), 16'h01A5);
    chk(16'(ready), 16'h0001);
  endtask

  // Reset in mid-write reruns setup
  task automatic t_reset_mid();
    pulse_byte(8'h41);
    repeat (100) @(posedge ref_clk) #1;
    t_init();
  endtask

  initial begin
    t_init();
    t_chars();
    t_busy();
    t_reset_mid();
    t_chars();
    report_and_stop();
  end
endmodule

bind lcw_ctrl lcw_ctrl_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_lcw_ctrl_chk (
  .ref_clk(ref_clk), .reset(reset), .host_byte_in(host_byte_in),
  .host_write(host_write), .ready(ready), .panel_reg_select(panel_reg_select),
  .panel_read_write(panel_read_write), .panel_strobe(panel_strobe), .panel_bus(panel_bus));

`default_nettype wire
